// >>> hdl/pwmc_pkg.sv
// ****************************************************************
// register map, field layout and channel state of the pwm core
// ****************************************************************
package pwmc_pkg;

    localparam int         PWMC_NUM_CH     = 4;

    // register byte offsets on the apb
    localparam logic [7:0] OFF_CLK_CAT     = 8'h00;
    localparam logic [7:0] OFF_SEL_POL     = 8'h04;
    localparam logic [7:0] OFF_ENABLE      = 8'h08;
    localparam logic [7:0] OFF_PRESCALE    = 8'h0C;
    localparam logic [7:0] OFF_SCALE0      = 8'h10;
    localparam logic [7:0] OFF_SCALE1      = 8'h14;
    localparam logic [7:0] OFF_CONTROL     = 8'h18;
    localparam logic [7:0] OFF_PIN_LEVEL   = 8'h1C;
    localparam logic [7:0] OFF_COUNTER0    = 8'h20;
    localparam logic [7:0] OFF_PERIOD0     = 8'h30;
    localparam logic [7:0] OFF_DUTY0       = 8'h40;

    // upper address nibble of the per-channel register groups
    localparam logic [3:0] GRP_COUNTER     = 4'h2;
    localparam logic [3:0] GRP_PERIOD      = 4'h3;
    localparam logic [3:0] GRP_DUTY        = 4'h4;

    // clocks_and_concatenate fields
    localparam int         FLD_JOIN_HI     = 7;
    localparam int         FLD_JOIN_LO     = 6;
    localparam int         FLD_CLKB_LSB    = 3;
    localparam int         FLD_CLKA_LSB    = 0;
    // clock_select_and_polarity fields
    localparam int         FLD_SRC_LSB     = 4;
    localparam int         FLD_POL_LSB     = 0;
    // control register field
    localparam int         FLD_CENTER      = 0;

    // reset values
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [6:0] RST_PRESCALE    = 7'h00;
    localparam logic [3:0] RST_NIBBLE      = 4'h0;

    // state of one channel counter and its active latches
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] per;
        logic [7:0] duty;
        logic       up;
        logic       en;
    } pwmc_chan_type;

    localparam pwmc_chan_type RST_CHAN = '{
        cnt: 8'h00, per: 8'h00, duty: 8'h00, up: 1'b1, en: 1'b0
    };

endpackage

// >>> hdl/pwmc_scaler.sv
`timescale 1ns/1ps

// ****************************************************************
// scaled clock: divides its input tick by (scale + 1) * 2
// ****************************************************************
module pwmc_scaler import pwmc_pkg::*; (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick_in,
    input  wire logic [7:0] scale,
    input  wire logic       load,
    output wire logic       tick_out
);

    logic [7:0] count;
    logic [7:0] next_count;
    logic       phase;
    logic       next_phase;

    // down counter reloads at zero, phase halves the reload rate
    always_comb begin
        next_count = count;
        next_phase = phase;
        if (load) begin
            next_count = scale;
        end else if (tick_in) begin
            if (count == 8'h00) begin
                next_count = scale;
                next_phase = ~phase;
            end else begin
                next_count = count - 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= RST_BYTE;
            phase <= 1'b0;
        end else begin
            count <= next_count;
            phase <= next_phase;
        end
    end

    // one pulse per two reloads
    assign tick_out = tick_in & ~load & (count == 8'h00) & phase;

endmodule // pwmc_scaler

// >>> hdl/pwmc_top.sv
`timescale 1ns/1ps

// Operation
// - four 8-bit channels, pairs may join 16-bit
// - enabled: new period/duty wait for rollover
// - disabled: writes reach active latches directly
// - counter write clears count, latches buffers
// - enabled channel owns its port pin
// - joined pair 2/3: pin 2, clock 3
// - joined pair 0/1: pin 0, clock 1
// - clock A is E over two-power field
// - clock B same encoding, channels 2/3
// - source bit picks A/B or scaled clock
// - source change may bend one pulse
// - start level from polarity, flip at duty
// - duty counts low or high time
// - enable forces pin output, direction bit kept
// - clocks gated; prescaler stops when all off
// - enable gating switches on clock ticks only
// - waveform starts on next source clock tick
// - 7-bit prescaler, written only in special mode
// - scaled clock 1 is B over even factor
// - channel counters readable while running
// - left or center aligned operation
// - scaled clock 0 is A/(scale+1)/2
// - left wraps at period, center reverses
// - toggle at duty, none if duty >= period
module pwmc_top import pwmc_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        special_mode_flag,
    input  wire logic [3:0]  pin_direction_bits,
    input  wire logic [3:0]  port_data,
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [7:0]    clk_cat;
    logic [7:0]    sel_pol;
    logic [3:0]    enable_channels;
    logic          center_align_sel;
    logic [7:0]    scale_value_0;
    logic [7:0]    scale_value_1;
    logic [7:0]    per_buf [PWMC_NUM_CH];
    logic [7:0]    duty_buf [PWMC_NUM_CH];
    logic [7:0]    next_clk_cat;
    logic [7:0]    next_sel_pol;
    logic [3:0]    next_enable;
    logic          next_center;
    logic [7:0]    next_scale0;
    logic [7:0]    next_scale1;
    logic [7:0]    next_per_buf [PWMC_NUM_CH];
    logic [7:0]    next_duty_buf [PWMC_NUM_CH];
    logic [6:0]    prescale_counter;
    logic [6:0]    next_prescale;
    logic [31:0]   next_prdata;
    logic          next_pready;
    logic          next_pslverr;
    logic [31:0]   rd_data;
    logic          mapped;
    logic          wr_en;
    logic          pres_wr;
    logic          scale0_wr;
    logic          scale1_wr;
    logic [3:0]    per_wr;
    logic [3:0]    cnt_wr;
    logic [3:0]    pin_meta;
    logic [3:0]    pin_sync;
    logic          run;
    logic          tick_a;
    logic          tick_b;
    logic          tick_s0;
    logic          tick_s1;
    pwmc_chan_type chan_q [PWMC_NUM_CH];
    logic [15:0]   u_next_cnt [PWMC_NUM_CH];
    logic          u_next_up [PWMC_NUM_CH];
    logic          u_latch [PWMC_NUM_CH];
    logic          u_level [PWMC_NUM_CH];
    logic          u_tick [PWMC_NUM_CH];
    logic [3:0]    next_pin_out;
    logic [3:0]    next_pin_oe;

    // ****************************************************************
    // apb slave
    // ****************************************************************

    // decode: word aligned, two scalar rows and three channel rows
    assign mapped = (paddr[1:0] == 2'b00) &&
                    ((paddr[7:5] == 3'b000) || (paddr[7:4] == GRP_COUNTER) ||
                     (paddr[7:4] == GRP_PERIOD) || (paddr[7:4] == GRP_DUTY));
    assign wr_en     = psel & penable & pready & pwrite & mapped;
    assign pres_wr   = wr_en & (paddr == OFF_PRESCALE);
    assign scale0_wr = wr_en & (paddr == OFF_SCALE0);
    assign scale1_wr = wr_en & (paddr == OFF_SCALE1);

    // read mux, counters return the live count
    always_comb begin
        rd_data = 32'h0000_0000;
        case (paddr)
            OFF_CLK_CAT:   rd_data[7:0] = clk_cat;
            OFF_SEL_POL:   rd_data[7:0] = sel_pol;
            OFF_ENABLE:    rd_data[3:0] = enable_channels;
            OFF_PRESCALE:  rd_data[6:0] = prescale_counter;
            OFF_SCALE0:    rd_data[7:0] = scale_value_0;
            OFF_SCALE1:    rd_data[7:0] = scale_value_1;
            OFF_CONTROL:   rd_data[FLD_CENTER] = center_align_sel;
            OFF_PIN_LEVEL: rd_data[3:0] = pin_sync;
            default: begin
                if (paddr[7:4] == GRP_COUNTER) begin
                    rd_data[7:0] = chan_q[paddr[3:2]].cnt;
                end else if (paddr[7:4] == GRP_PERIOD) begin
                    rd_data[7:0] = per_buf[paddr[3:2]];
                end else if (paddr[7:4] == GRP_DUTY) begin
                    rd_data[7:0] = duty_buf[paddr[3:2]];
                end
            end
        endcase
    end

    // zero-wait answer: ready and data come in the first access cycle
    always_comb begin
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~mapped;
        next_prdata  = (psel & ~penable & ~pwrite) ? rd_data : prdata;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ****************************************************************
    // control registers and period/duty buffers
    // ****************************************************************

    // software writes land here; channel rows hold the buffered values
    always_comb begin
        next_clk_cat = clk_cat;
        next_sel_pol = sel_pol;
        next_enable  = enable_channels;
        next_center  = center_align_sel;
        next_scale0  = scale_value_0;
        next_scale1  = scale_value_1;
        if (wr_en && (paddr == OFF_CLK_CAT)) next_clk_cat = pwdata[7:0];
        if (wr_en && (paddr == OFF_SEL_POL)) next_sel_pol = pwdata[7:0];
        if (wr_en && (paddr == OFF_ENABLE))  next_enable  = pwdata[3:0];
        if (wr_en && (paddr == OFF_CONTROL)) next_center  = pwdata[FLD_CENTER];
        if (scale0_wr) next_scale0 = pwdata[7:0];
        if (scale1_wr) next_scale1 = pwdata[7:0];
        for (int c = 0; c < PWMC_NUM_CH; c++) begin
            next_per_buf[c]  = per_buf[c];
            next_duty_buf[c] = duty_buf[c];
            if (per_wr[c]) next_per_buf[c] = pwdata[7:0];
            if (wr_en && (paddr[7:4] == GRP_DUTY) && (paddr[3:2] == 2'(c))) begin
                next_duty_buf[c] = pwdata[7:0];
            end
        end
    end

    // all control state clears on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_cat          <= RST_BYTE;
            sel_pol          <= RST_BYTE;
            enable_channels  <= RST_NIBBLE;
            center_align_sel <= 1'b0;
            scale_value_0    <= RST_BYTE;
            scale_value_1    <= RST_BYTE;
            for (int c = 0; c < PWMC_NUM_CH; c++) begin
                per_buf[c]  <= RST_BYTE;
                duty_buf[c] <= RST_BYTE;
            end
        end else begin
            clk_cat          <= next_clk_cat;
            sel_pol          <= next_sel_pol;
            enable_channels  <= next_enable;
            center_align_sel <= next_center;
            scale_value_0    <= next_scale0;
            scale_value_1    <= next_scale1;
            for (int c = 0; c < PWMC_NUM_CH; c++) begin
                per_buf[c]  <= next_per_buf[c];
                duty_buf[c] <= next_duty_buf[c];
            end
        end
    end

    // ****************************************************************
    // prescaler, clock A/B ticks and scaled clocks
    // ****************************************************************

    // tick when the low sel bits of the prescaler are all ones
    function automatic logic div_tick(input logic [6:0] cnt, input logic [2:0] sel);
        logic [7:0] mask;
        mask = (8'h01 << sel) - 8'h01;
        return &(cnt | ~mask[6:0]);
    endfunction

    assign run = |enable_channels;

    // free running while any channel is on, writable in special mode
    always_comb begin
        next_prescale = prescale_counter;
        if (run) next_prescale = prescale_counter + 7'h01;
        if (pres_wr && special_mode_flag) next_prescale = pwdata[6:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_counter <= RST_PRESCALE;
        end else begin
            prescale_counter <= next_prescale;
        end
    end

    assign tick_a = run & div_tick(prescale_counter, clk_cat[FLD_CLKA_LSB +: 3]);
    assign tick_b = run & div_tick(prescale_counter, clk_cat[FLD_CLKB_LSB +: 3]);

    // scaled clock 0 from clock A, scaled clock 1 from clock B
    pwmc_scaler u_scale0 (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick_in  (tick_a),
        .scale    (scale_value_0),
        .load     (scale0_wr),
        .tick_out (tick_s0)
    );

    pwmc_scaler u_scale1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick_in  (tick_b),
        .scale    (scale_value_1),
        .load     (scale1_wr),
        .tick_out (tick_s1)
    );

    // ****************************************************************
    // channels: each low channel can carry its pair as one 16-bit unit
    // ****************************************************************
    for (genvar c = 0; c < PWMC_NUM_CH; c++) begin : g_ch
        localparam int HI   = c - (c % 2);
        localparam int LO   = HI + 1;
        localparam int MATE = HI + LO - c;
        logic          join_p;
        logic          hi_half;
        logic          src;
        logic          base_tick;
        logic          en_sw;
        logic          pol;
        logic          clr;
        logic [15:0]   ucnt;
        logic [15:0]   uper;
        logic [15:0]   uduty;
        logic [15:0]   next_ucnt;
        logic          next_up;
        logic          latch;
        pwmc_chan_type q;
        pwmc_chan_type next_q;

        assign join_p  = (HI == 0) ? clk_cat[FLD_JOIN_LO] : clk_cat[FLD_JOIN_HI];
        assign hi_half = join_p && (c == HI);
        // joined pair runs from the low channel's source and clock
        assign src     = sel_pol[FLD_SRC_LSB + (join_p ? LO : c)];
        assign base_tick = (HI == 0) ? (src ? tick_s0 : tick_a)
                                     : (src ? tick_s1 : tick_b);
        assign en_sw   = join_p ? enable_channels[HI] : enable_channels[c];
        assign pol     = sel_pol[FLD_POL_LSB + (join_p ? HI : c)];
        assign per_wr[c] = wr_en && (paddr[7:4] == GRP_PERIOD) && (paddr[3:2] == 2'(c));
        assign cnt_wr[c] = wr_en && (paddr[7:4] == GRP_COUNTER) && (paddr[3:2] == 2'(c));
        assign clr     = cnt_wr[c] | (join_p & cnt_wr[MATE]);
        assign u_tick[c] = base_tick & q.en;
        assign ucnt    = join_p ? {chan_q[HI].cnt, chan_q[LO].cnt} : {8'h00, q.cnt};
        assign uper    = join_p ? {chan_q[HI].per, chan_q[LO].per} : {8'h00, q.per};
        assign uduty   = join_p ? {chan_q[HI].duty, chan_q[LO].duty} : {8'h00, q.duty};

        // unit counter: left wraps at period, center bounces
        always_comb begin
            next_ucnt = ucnt;
            next_up   = q.up;
            latch     = 1'b0;
            if (u_tick[c]) begin
                if (!center_align_sel) begin
                    if (ucnt == uper) begin
                        next_ucnt = 16'h0000;
                        latch     = 1'b1;
                    end else begin
                        next_ucnt = ucnt + 16'h0001;
                    end
                end else if (q.up) begin
                    if (ucnt >= uper) begin
                        next_up   = 1'b0;
                        next_ucnt = (ucnt == 16'h0000) ? ucnt : ucnt - 16'h0001;
                    end else begin
                        next_ucnt = ucnt + 16'h0001;
                    end
                end else if (ucnt == 16'h0000) begin
                    next_up   = 1'b1;
                    latch     = 1'b1;
                    next_ucnt = (uper == 16'h0000) ? 16'h0000 : 16'h0001;
                end else begin
                    next_ucnt = ucnt - 16'h0001;
                end
            end
            if (clr) begin
                next_ucnt = 16'h0000;
                next_up   = 1'b1;
                latch     = 1'b1;
            end
        end

        assign u_next_cnt[c] = next_ucnt;
        assign u_next_up[c]  = next_up;
        assign u_latch[c]    = latch;
        // start level until the count passes duty; no flip if duty >= period
        assign u_level[c]    = pol ^ ((uduty < uper) && (ucnt > uduty));

        // channel state: high half of a joined pair follows the low unit
        always_comb begin
            next_q     = q;
            next_q.en  = base_tick ? en_sw : q.en;
            next_q.cnt = hi_half ? u_next_cnt[LO][15:8] : u_next_cnt[c][7:0];
            next_q.up  = hi_half ? u_next_up[LO] : u_next_up[c];
            if ((hi_half ? u_latch[LO] : u_latch[c]) || !en_sw) begin
                next_q.per  = per_buf[c];
                next_q.duty = duty_buf[c];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                q <= RST_CHAN;
            end else begin
                q <= next_q;
            end
        end

        assign chan_q[c] = q;

        // pin: enable forces output and waveform (polarity on the odd channel of a joined pair), else port data/direction
        assign next_pin_oe[c]  = enable_channels[c] | pin_direction_bits[c];
        assign next_pin_out[c] = !enable_channels[c] ? port_data[c] :
                                 hi_half ? u_level[LO] :
                                 join_p ? sel_pol[FLD_POL_LSB + c] : u_level[c];
    end

    // ****************************************************************
    // pins
    // ****************************************************************

    // registered pin drive and two-stage input synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out  <= RST_NIBBLE;
            pin_oe   <= RST_NIBBLE;
            pin_meta <= RST_NIBBLE;
            pin_sync <= RST_NIBBLE;
        end else begin
            pin_out  <= next_pin_out;
            pin_oe   <= next_pin_oe;
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    prescale_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_channels == 4'h0) && !pres_wr |=> $stable(prescale_counter))
        else $error("prescaler moved with all channels off");

    prescale_normal_a: assert property (@(posedge pclk) disable iff (!presetn)
        pres_wr && !special_mode_flag |=>
        (prescale_counter == $past(prescale_counter)) ||
        (prescale_counter == $past(prescale_counter) + 7'h01))
        else $error("prescaler written outside special mode");

    counter_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_wr[1] |=> (chan_q[1].cnt == 8'h00) && (chan_q[1].per == $past(per_buf[1])))
        else $error("counter write did not clear and latch");

    period_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
        per_wr[1] && !enable_channels[1] && !cnt_wr[1] ##1 !enable_channels[1]
        |=> chan_q[1].per == $past(pwdata[7:0], 2))
        else $error("disabled period write not applied");

    period_buffer_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_channels[1] && !clk_cat[FLD_JOIN_LO] && !u_latch[1] && !cnt_wr[1]
        |=> $stable(chan_q[1].per))
        else $error("active period changed before rollover");

    left_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        u_tick[1] && !center_align_sel && !clk_cat[FLD_JOIN_LO] && !cnt_wr[1] &&
        (chan_q[1].cnt == chan_q[1].per) |=> chan_q[1].cnt == 8'h00)
        else $error("left aligned counter missed its wrap");

    oe_force_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_channels[2] |=> pin_oe[2])
        else $error("enabled channel pin not driven");

    no_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
        enable_channels[3] && !clk_cat[FLD_JOIN_HI] &&
        (chan_q[3].duty >= chan_q[3].per) |=> pin_out[3] == $past(sel_pol[FLD_POL_LSB + 3]))
        else $error("output toggled with duty at or above period");

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready && (pslverr == !$past(mapped)))
        else $error("apb answer missing");

endmodule // pwmc_top

// >>> dv/pwmc_load.sv
`timescale 1ns/1ps

// ****************************************************************
// external loads on the shared port pins
// ****************************************************************
module pwmc_load (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] pin_in
);
    // driven pins show their level, released pins sit on the pull-up
    assign pin_in = (pin_out & pin_oe) | ~pin_oe;
endmodule // pwmc_load

// >>> dv/pwmc_top_test.sv
`timescale 1ns/1ps

// ****************************************************************
// self-checking bench of the pwm core
// ****************************************************************
module pwmc_top_test;
    import pwmc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, special_mode_flag, pready, pslverr, pol;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, se;
    logic [3:0]  pin_direction_bits, port_data, pin_in, pin_out, pin_oe;
    logic        ctr, src;
    int          err_total, checks, cyc, hi, per, duty, div, n, sc, e;

    pwmc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .special_mode_flag, .pin_direction_bits, .port_data, .pin_in,
        .pin_out, .pin_oe);
    pwmc_load load (.pin_out, .pin_oe, .pin_in);

    // one apb transfer, held until pready is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; se = {31'h0, pslverr};
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // high cycles over len cycles: left has pr+1 states, center 2*pr states
    function automatic int exp_hi(logic p, logic c, int pr, int dt, int len);
        int h;
        if (dt >= pr) return p ? len : 0;
        h = c ? 2 * (pr - dt) - 1 : pr - dt;
        return len * (p ? (c ? 2 * pr : pr + 1) - h : h) / (c ? 2 * pr : pr + 1);
    endfunction

    task automatic conclude;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk) if (++cyc == 30000) begin
        err_total++;
        conclude;
    end

    initial begin
        {presetn, psel, penable, pwrite, special_mode_flag} = '0;
        paddr = '0; pwdata = '0; pin_direction_bits = '0; port_data = '0;
        err_total = 0; checks = 0; cyc = 0;
        void'($urandom(32'h5FF4));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 8'h1C; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk(q, 32'h0);
        end
        bus(1'b0, 8'h50, 32'h0);
        chk(se, 32'h1);
        bus(1'b0, OFF_PIN_LEVEL, 32'h0);
        chk(q, 32'hF);
        bus(1'b1, OFF_PRESCALE, 32'h55);
        bus(1'b0, OFF_PRESCALE, 32'h0);
        chk(q, 32'h0);
        special_mode_flag <= 1'b1;
        bus(1'b1, OFF_PRESCALE, 32'h55);
        bus(1'b0, OFF_PRESCALE, 32'h0);
        chk(q, 32'h55);
        special_mode_flag <= 1'b0;
        bus(1'b1, OFF_PERIOD0 + 8'h04, 32'h3);
        bus(1'b1, OFF_ENABLE, 32'hF);
        repeat (2) @(posedge pclk);
        chk(32'(pin_oe), 32'hF);
        // random periods, duties, polarities, alignments and sources on channel 1
        for (int i = 0; i < 10; i++) begin
            per = 2 + $urandom % 6;
            duty = (i == 0) ? per : (i == 1) ? 0 : $urandom % (per + 1);
            pol = 1'($urandom);
            ctr = 1'($urandom);
            src = 1'($urandom);
            sc = $urandom % 2;
            div = $urandom % 3;
            bus(1'b1, OFF_PERIOD0 + 8'h04, 32'(per));
            bus(1'b1, OFF_DUTY0 + 8'h04, 32'(duty));
            bus(1'b1, OFF_SEL_POL, 32'({src, 3'h0, pol, 1'b0}));
            bus(1'b1, OFF_CLK_CAT, 32'(div));
            bus(1'b1, OFF_SCALE0, 32'(sc));
            bus(1'b1, OFF_CONTROL, 32'(ctr));
            bus(1'b1, OFF_COUNTER0 + 8'h04, 32'h0);
            repeat (50) @(posedge pclk);
            n = ((4 * (ctr ? 2 * per : per + 1)) * (src ? 2 * (sc + 1) : 1)) << div;
            e = exp_hi(pol, ctr, per, duty, n);
            hi = 0;
            repeat (n) @(posedge pclk) hi += pin_out[1];
            chk(32'(hi), 32'(e));
        end
        // pair 0/1 joined: one 16-bit unit on pin 0, pin 1 shows its own polarity
        bus(1'b1, OFF_CONTROL, 32'h0);
        bus(1'b1, OFF_PERIOD0, 32'h1);
        bus(1'b1, OFF_PERIOD0 + 8'h04, 32'h0);
        bus(1'b1, OFF_DUTY0, 32'h0);
        bus(1'b1, OFF_DUTY0 + 8'h04, 32'h80);
        bus(1'b1, OFF_SEL_POL, 32'h2);
        bus(1'b1, OFF_CLK_CAT, 32'h40);
        bus(1'b1, OFF_COUNTER0, 32'h0);
        repeat (50) @(posedge pclk);
        hi = 0;
        repeat (514) @(posedge pclk) hi += pin_out[0];
        chk(32'(hi), 32'(exp_hi(1'b0, 1'b0, 256, 128, 514)));
        chk(32'(pin_out[1]), 32'h1);
        bus(1'b1, OFF_ENABLE, 32'h0);
        // disabled pins return to general-purpose use
        for (int i = 0; i < 8; i++) begin
            pin_direction_bits <= 4'($urandom);
            port_data <= 4'($urandom);
            repeat (3) @(posedge pclk);
            chk(32'(pin_oe), 32'(pin_direction_bits));
            chk(32'(pin_out & pin_direction_bits), 32'(port_data & pin_direction_bits));
        end
        conclude;
    end
endmodule // pwmc_top_test
